/* dsc_pkg.sv */
package dsc_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ADDR_W    = 4;   // register address width
	localparam int DATA_W    = 16;  // register data width
	localparam int CNT_W     = 10;  // pwm down counter width
	localparam int PER_W     = 11;  // period width, holds 4 x 256
	localparam int DIV_W     = 8;   // data clock divider width
	localparam int SRC_W     = 4;   // input source select width
	localparam int GAIN_W    = 5;   // inverting gain in sixteenths
	localparam int ROW_SEL_W = 2;   // row bus select width
	localparam int STAT_W    = 2;   // status and mask width

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] A_CTRL   = 4'h0; // run, format, phase
	localparam logic [ADDR_W-1:0] A_POWER  = 4'h1; // power level
	localparam logic [ADDR_W-1:0] A_INPUT  = 4'h2; // sources and gain
	localparam logic [ADDR_W-1:0] A_DUTY   = 4'h3; // duty compare value
	localparam logic [ADDR_W-1:0] A_ROUTE  = 4'h4; // pwm row routing
	localparam logic [ADDR_W-1:0] A_CMD    = 4'h5; // commands
	localparam logic [ADDR_W-1:0] A_SAMPLE = 4'h6; // converted sample
	localparam logic [ADDR_W-1:0] A_STATUS = 4'h7; // sticky events
	localparam logic [ADDR_W-1:0] A_MASK   = 4'h8; // interrupt mask

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_RUN    = 0; // pwm time base enable
	localparam int CTRL_SIGNED = 1; // sample_number_format, 1 signed
	localparam int CTRL_PHASE  = 2; // acquire on second phase
	localparam int CTRL_DEC_LO = 3; // decimation select, two bits
	localparam int IN_POS_LO   = 0; // noninverting_source_select
	localparam int IN_NEG_LO   = 4; // inverting_source_select
	localparam int IN_GAIN_LO  = 8; // inverting_input_gain
	localparam int ROUTE_EN    = 0; // drive pwm onto a row bus
	localparam int ROUTE_SEL_LO = 1; // which row bus
	localparam int CMD_STOP    = 0; // stop command bit
	localparam int ST_SAMPLE   = 0; // new sample event
	localparam int ST_SKIP     = 1; // invalid result dropped

	// ****************************************************************
	// encodings and constants
	// ****************************************************************
	typedef enum logic [1:0] {
		power_level_off    = 2'b00,
		power_level_low    = 2'b01,
		power_level_medium = 2'b10,
		power_level_high   = 2'b11
	} dsc_power_t;

	localparam int DEC_BASE_LOG2  = 5;  // smallest decimation is 32
	localparam int PER_MULT_LOG2  = 2;  // period is four times rate
	localparam logic [GAIN_W-1:0] GAIN_OFF   = 5'h00; // disconnected
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 5'h10; // 16/16
	localparam logic [1:0] SKIP_AFTER_RESTORE = 2'h2;

	// ****************************************************************
	// state of the control block
	// ****************************************************************
	typedef struct packed {
		logic [DIV_W-1:0]     div;       // data clock divider
		logic                 den;       // data clock enable pulse
		logic [CNT_W-1:0]     cnt;       // pwm down counter
		logic                 run;       // time base enabled
		logic                 signed_fmt; // signed sample format
		logic                 phase2;    // acquire on phase two
		logic [1:0]           dec_sel;   // decimation 32..256
		dsc_power_t           power;     // analog power level
		logic [SRC_W-1:0]     pos_sel;   // noninverting source
		logic [SRC_W-1:0]     neg_sel;   // inverting source
		logic [GAIN_W-1:0]    neg_gain;  // inverting gain
		logic                 neg_conn;  // inverting path connected
		logic [CNT_W-1:0]     duty;      // duty compare value
		logic                 route_en;  // row routing enabled
		logic [ROW_SEL_W-1:0] route_sel; // chosen row bus
		logic [(1<<ROW_SEL_W)-1:0] row;  // row bus drive
		logic                 pwm;       // pwm output
		logic                 hit;       // counter reached zero
		logic                 sevt;      // sample taken pulse
		logic [1:0]           skip;      // results still invalid
		logic [DATA_W-1:0]    sample;    // last converted sample
		logic [STAT_W-1:0]    stat;      // sticky events
		logic [STAT_W-1:0]    mask;      // interrupt mask
		logic                 irq;       // interrupt output
		logic [DATA_W-1:0]    rdata;     // read data
	} dsc_state_t;

endpackage

/* dsc_timing_ctrl.sv */
// Behaviour
// [RULE_01] samples unsigned or signed, signed by default
// [RULE_02] one data clock for column and digital
// [RULE_03] data clock feeds every converter block
// [RULE_04] sample interrupt every four times decimation counts
// [RULE_05] each sample interrupt captures decimator result
// [RULE_06] acquire on phase one, swap to two
// [RULE_07] positive select picks noninverting source
// [RULE_08] zero inverting gain disconnects inverting input
// [RULE_09] inverting gain in sixteenths, unity for differential
// [RULE_10] pwm optionally driven onto chosen row bus
// [RULE_11] sample at terminal count, pwm falling
// [RULE_12] initial compare between one and period-1
// [RULE_13] zero compare stops samples, converter keeps running
// [RULE_14] power levels off, low, medium, high
// [RULE_15] analog block off until power written
// [RULE_16] stop command sets power off
// [RULE_17] two results invalid after compare restored
// [RULE_18] full duty also stops sample production
// [RULE_19] counter reloads period minus one each wrap
module dsc_timing_ctrl
	import dsc_pkg::*;
#(
	parameter int DATA_DIV = 16, // core clocks per data clock
	parameter int RES_BITS = 14  // sample resolution in bits
) (
	input  wire  logic                        core_clk,      // core clock
	input  wire  logic                        nrst,          // reset, low
	input  wire  logic [dsc_pkg::ADDR_W-1:0]  reg_addr,      // address
	input  wire  logic [dsc_pkg::DATA_W-1:0]  reg_wdata,     // write data
	input  wire  logic                        reg_wr,        // write pulse
	input  wire  logic                        reg_rd,        // read pulse
	output logic [dsc_pkg::DATA_W-1:0]        reg_rdata,     // read data
	input  wire  logic [dsc_pkg::DATA_W-1:0]  dec_result,    // decimator
	output logic                              col_clk_en,    // data clock
	output logic                              acquire_phase2, // swap
	output logic [dsc_pkg::SRC_W-1:0]         noninverting_source_select,
	output logic [dsc_pkg::SRC_W-1:0]         inverting_source_select,
	output logic [dsc_pkg::GAIN_W-1:0]        inverting_input_gain,
	output logic                              inverting_connected, // path
	output dsc_pkg::dsc_power_t               power_level,   // sc power
	output logic                              pwm_out,       // pwm
	output logic [(1<<dsc_pkg::ROW_SEL_W)-1:0] row_bus_out,  // row drive
	output logic                              sample_strobe, // new sample
	output logic [dsc_pkg::DATA_W-1:0]        sample_data,   // sample
	output logic                              irq            // interrupt
);
	import dsc_pkg::*;

	// ****************************************************************
	// reset image
	// ****************************************************************
	localparam dsc_state_t RST_STATE = '{
		div: '0, den: 1'b0, cnt: '0, run: 1'b0, signed_fmt: 1'b1,
		phase2: 1'b0, dec_sel: 2'h3, power: power_level_off,
		pos_sel: '0, neg_sel: '0, neg_gain: GAIN_OFF, neg_conn: 1'b0,
		duty: 10'h1ff, route_en: 1'b0, route_sel: '0, row: '0,
		pwm: 1'b0, hit: 1'b0, sevt: 1'b0, skip: '0, sample: '0,
		stat: '0, mask: '0, irq: 1'b0, rdata: '0
	};
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DATA_DIV - 1);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// period is four times the decimation rate
	function automatic logic [PER_W-1:0] period_of(input logic [1:0] sel);
		period_of = PER_W'(1) << (DEC_BASE_LOG2 + PER_MULT_LOG2 + int'(sel));
	endfunction

	// decimator gives offset binary; signed flips the top bit
	function automatic logic [DATA_W-1:0] fmt_sample(
		input logic [DATA_W-1:0] raw,
		input logic              sgn
	);
		logic [DATA_W-1:0] v;
		v = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (i < RES_BITS - 1)
				v[i] = raw[i];
			else if (sgn)
				v[i] = ~raw[RES_BITS-1];
			else if (i == RES_BITS - 1)
				v[i] = raw[i];
		end
		fmt_sample = v;
	endfunction

	// compare strictly inside the period lets samples through
	function automatic logic duty_valid(
		input logic [CNT_W-1:0] d,
		input logic [1:0]       sel
	);
		duty_valid = (d != '0) && ({1'b0, d} < period_of(sel));
	endfunction

	dsc_state_t           st;      // registered state
	dsc_state_t           next_st; // next state
	logic [PER_W-1:0]     period;  // current period
	logic [CNT_W-1:0]     per_m1;  // reload value
	logic                 duty_ok; // compare inside the period
	logic [STAT_W-1:0]    set_ev;  // events this cycle
	logic [STAT_W-1:0]    clr_ev;  // cleared by status read

	assign period  = period_of(st.dec_sel);
	assign per_m1  = CNT_W'(period - PER_W'(1));
	assign duty_ok = duty_valid(st.duty, st.dec_sel);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		next_st.den = 1'b0;
		next_st.hit = 1'b0;
		next_st.sevt = 1'b0;
		set_ev = '0;
		clr_ev = '0;

		// one enable serves column and digital alike
		if (st.div == DIV_LAST) begin // RULE_02
			next_st.div = '0;
			next_st.den = 1'b1; // RULE_03
		end else begin
			next_st.div = st.div + DIV_W'(1);
		end

		// down counter, held at reload while stopped
		if (!st.run) begin
			next_st.cnt = per_m1;
		end else if (st.den) begin
			if (st.cnt == '0) begin
				next_st.cnt = per_m1; // RULE_19
			end else begin
				next_st.cnt = st.cnt - CNT_W'(1);
				next_st.hit = (st.cnt == CNT_W'(1)); // RULE_04
			end
		end

		// high for duty counts, falling as zero is reached
		if (!st.run || st.duty == '0) begin
			next_st.pwm = 1'b0; // RULE_13
		end else if ({1'b0, st.duty} >= period) begin
			next_st.pwm = 1'b1; // RULE_18
		end else begin
			next_st.pwm = (next_st.cnt != '0) &&
				(next_st.cnt <= st.duty); // RULE_11
		end

		// capture at terminal count; extremes give no sample
		if (next_st.hit && duty_ok) begin // RULE_13 RULE_18
			if (st.skip != '0) begin
				next_st.skip = st.skip - 2'h1; // RULE_17
				set_ev[ST_SKIP] = 1'b1;
			end else begin
				next_st.sample = fmt_sample(dec_result,
					st.signed_fmt); // RULE_05 RULE_01
				next_st.sevt = 1'b1;
				set_ev[ST_SAMPLE] = 1'b1;
			end
		end

		// register writes
		if (reg_wr) begin
			if (reg_addr == A_CTRL) begin
				next_st.run = reg_wdata[CTRL_RUN];
				next_st.signed_fmt = reg_wdata[CTRL_SIGNED]; // RULE_01
				next_st.phase2 = reg_wdata[CTRL_PHASE]; // RULE_06
				next_st.dec_sel = reg_wdata[CTRL_DEC_LO +: 2];
				// a start that also picks a new rate must begin
				// with the new period, not the one held while idle
				if (!st.run) begin
					next_st.cnt = CNT_W'(period_of(
						reg_wdata[CTRL_DEC_LO +: 2]) - PER_W'(1)); // RULE_19
				end
			end else if (reg_addr == A_POWER) begin
				next_st.power = dsc_power_t'(reg_wdata[1:0]); // RULE_14
			end else if (reg_addr == A_INPUT) begin
				next_st.pos_sel = reg_wdata[IN_POS_LO +: SRC_W]; // RULE_07
				next_st.neg_sel = reg_wdata[IN_NEG_LO +: SRC_W];
				next_st.neg_gain = reg_wdata[IN_GAIN_LO +: GAIN_W]; // RULE_09
			end else if (reg_addr == A_DUTY) begin
				next_st.duty = reg_wdata[CNT_W-1:0];
				// restoring from zero spoils the next two results
				if (st.duty == '0 && reg_wdata[CNT_W-1:0] != '0) begin
					next_st.skip = SKIP_AFTER_RESTORE; // RULE_17
				end
			end else if (reg_addr == A_ROUTE) begin
				next_st.route_en = reg_wdata[ROUTE_EN];
				next_st.route_sel = reg_wdata[ROUTE_SEL_LO +: ROW_SEL_W];
			end else if (reg_addr == A_CMD) begin
				if (reg_wdata[CMD_STOP]) begin
					next_st.power = power_level_off; // RULE_16
				end
			end else if (reg_addr == A_MASK) begin
				next_st.mask = reg_wdata[STAT_W-1:0];
			end
		end

		// zero gain isolates the inverting source
		next_st.neg_conn = (next_st.neg_gain != GAIN_OFF); // RULE_08

		// one row bus at most carries the pwm
		for (int i = 0; i < (1 << ROW_SEL_W); i++) begin
			next_st.row[i] = next_st.route_en && next_st.pwm &&
				(next_st.route_sel == ROW_SEL_W'(i)); // RULE_10
		end

		// register reads, data in the following cycle
		next_st.rdata = '0;
		if (reg_rd) begin
			if (reg_addr == A_CTRL) begin
				next_st.rdata[CTRL_RUN] = st.run;
				next_st.rdata[CTRL_SIGNED] = st.signed_fmt;
				next_st.rdata[CTRL_PHASE] = st.phase2;
				next_st.rdata[CTRL_DEC_LO +: 2] = st.dec_sel;
			end else if (reg_addr == A_POWER) begin
				next_st.rdata[1:0] = st.power;
			end else if (reg_addr == A_INPUT) begin
				next_st.rdata[IN_POS_LO +: SRC_W] = st.pos_sel;
				next_st.rdata[IN_NEG_LO +: SRC_W] = st.neg_sel;
				next_st.rdata[IN_GAIN_LO +: GAIN_W] = st.neg_gain;
			end else if (reg_addr == A_DUTY) begin
				next_st.rdata[CNT_W-1:0] = st.duty;
			end else if (reg_addr == A_ROUTE) begin
				next_st.rdata[ROUTE_EN] = st.route_en;
				next_st.rdata[ROUTE_SEL_LO +: ROW_SEL_W] = st.route_sel;
			end else if (reg_addr == A_SAMPLE) begin
				next_st.rdata = st.sample;
			end else if (reg_addr == A_STATUS) begin
				next_st.rdata[STAT_W-1:0] = st.stat;
				clr_ev = st.stat;
			end else if (reg_addr == A_MASK) begin
				next_st.rdata[STAT_W-1:0] = st.mask;
			end
		end

		// a new event outlives a read in the same cycle
		next_st.stat = (st.stat & ~clr_ev) | set_ev;
		next_st.irq = |(next_st.stat & next_st.mask);
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st <= RST_STATE; // RULE_15
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign reg_rdata                  = st.rdata;
	assign col_clk_en                 = st.den;
	assign acquire_phase2             = st.phase2;
	assign noninverting_source_select = st.pos_sel;
	assign inverting_source_select    = st.neg_sel;
	assign inverting_input_gain       = st.neg_gain;
	assign inverting_connected        = st.neg_conn;
	assign power_level                = st.power;
	assign pwm_out                    = st.pwm;
	assign row_bus_out                = st.row;
	assign sample_strobe              = st.sevt;
	assign sample_data                = st.sample;
	assign irq                        = st.irq;

	// ****************************************************************
	// checks
	// ****************************************************************

	// enables seen between two terminal counts
	logic [PER_W:0] ast_gap;  // enables since last terminal count
	logic           ast_ok;   // a full undisturbed period passed
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ast_gap <= '0;
			ast_ok <= 1'b0;
		end else begin
			if (st.hit) begin
				ast_gap <= {PER_W'(0), st.den};
			end else begin
				ast_gap <= ast_gap + {PER_W'(0), st.den};
			end
			if (reg_wr || !st.run) begin
				ast_ok <= 1'b0;
			end else if (st.hit) begin
				ast_ok <= 1'b1;
			end
		end
	end

	sequence s_restore;
		reg_wr && reg_addr == A_DUTY && st.duty == '0 &&
			reg_wdata[CNT_W-1:0] != '0;
	endsequence
	sequence s_stop;
		reg_wr && reg_addr == A_CMD && reg_wdata[CMD_STOP];
	endsequence

	AST_FORMAT: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_01
		st.sevt |-> st.sample ==
			fmt_sample($past(dec_result), $past(st.signed_fmt)))
		else $error("sample format does not follow setting");
	AST_DATA_CLOCK: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_02
		(st.run && $past(st.run) && st.cnt != $past(st.cnt)) |->
			$past(st.den))
		else $error("counter moved without data clock");
	AST_PERIOD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_04
		(st.hit && ast_ok && !$past(reg_wr)) |->
			ast_gap == {1'b0, period})
		else $error("terminal counts not one period apart");
	AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_05
		st.sevt |-> st.stat[ST_SAMPLE] ##1 !st.sevt)
		else $error("sample taken without status");
	AST_PHASE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_06
		(reg_wr && reg_addr == A_CTRL) |=>
			acquire_phase2 == $past(reg_wdata[CTRL_PHASE]))
		else $error("phase swap not applied");
	AST_NEG_OFF: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_08
		inverting_connected == (inverting_input_gain != GAIN_OFF))
		else $error("inverting path state wrong");
	AST_ROUTE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_10
		(row_bus_out != '0) |-> pwm_out && st.route_en)
		else $error("row bus driven without pwm");
	AST_FALL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_11
		st.sevt |-> $fell(pwm_out) && st.cnt == '0)
		else $error("sample not at pwm falling edge");
	AST_EXTREMES: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_13
		st.sevt |-> $past(duty_ok))
		else $error("sample at zero or full duty");
	AST_POWER: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
		(reg_wr && reg_addr == A_POWER) |=>
			power_level == dsc_power_t'($past(reg_wdata[1:0])))
		else $error("power level not taken");
	AST_STOP: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_16
		s_stop |=> power_level == power_level_off)
		else $error("stop did not power off");
	AST_RESTORE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_17
		s_restore ##1 !st.hit |-> st.skip == SKIP_AFTER_RESTORE)
		else $error("restore did not mark two invalid results");
	AST_RELOAD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_19
		(st.run && st.den && st.cnt == '0 && !reg_wr) |=>
			st.cnt == per_m1)
		else $error("counter did not reload");

endmodule

/* dsc_column_model.sv */
module dsc_column_model
	import dsc_pkg::*;
(
	input  wire  logic                 core_clk,      // shared core clock
	input  wire  logic                 nrst,          // reset, low
	input  wire  logic                 col_clk_en,    // column step pulse
	input  wire  logic                 sample_strobe, // result was taken
	output logic [dsc_pkg::DATA_W-1:0] dec_result     // decimator word
);
	import dsc_pkg::*;

	// ****************************************************************
	// modulator and decimator stand-in
	// ****************************************************************
	logic [13:0] acc; // integrates column steps

	// the column runs on the same enable as the time base
	// the result only moves after a take, so the taken word is stable
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			acc <= 14'h0000;
			dec_result <= 16'h2a5a;
		end else begin
			if (col_clk_en)
				acc <= acc + 14'h0013;
			if (sample_strobe)
				dec_result <= {2'b00, acc ^ 14'h1c3e};
		end
	end
endmodule

/* tb_delta_sigma_adc_timing_control.sv */
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
	errors++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb_delta_sigma_adc_timing_control;
	timeunit 1ns;
	timeprecision 1ps;
	import dsc_pkg::*;

	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int DIV = 2;         // short data clock for fast runs
	localparam int PER = 128 * DIV; // core cycles per sample, rate 32
	logic              core_clk = 0; // core clock
	logic              nrst;         // reset, low
	logic [ADDR_W-1:0] reg_addr;     // register address
	logic [DATA_W-1:0] reg_wdata;    // write data
	logic              reg_wr;       // write strobe
	logic              reg_rd;       // read strobe
	logic [DATA_W-1:0] reg_rdata;    // read data
	logic [DATA_W-1:0] dec_result;   // from column model
	logic              col_clk_en;   // data clock enable
	logic              ph2;          // phase swap
	logic [SRC_W-1:0]  pos_src;      // noninverting source
	logic [SRC_W-1:0]  neg_src;      // inverting source
	logic [GAIN_W-1:0] gain;         // inverting gain
	logic              neg_on;       // inverting path connected
	dsc_power_t        power_level;  // power level
	logic              pwm_out;      // pwm
	logic [3:0]        row_bus_out;  // row buses
	logic              sample_strobe; // new sample
	logic [DATA_W-1:0] sample_data;  // sample
	logic              irq;          // interrupt
	int                errors = 0;   // mismatches
	int                checks = 0;   // comparisons
	int                cycles = 0;   // timeout counter
	logic              last_pwm;     // pwm before the last edge
	logic [3:0]        last_row;     // row drive before the last edge

	always #4 core_clk = ~core_clk;

	dsc_timing_ctrl #(.DATA_DIV(DIV), .RES_BITS(14)) u_dut (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dec_result(dec_result),
		.col_clk_en(col_clk_en), .acquire_phase2(ph2),
		.noninverting_source_select(pos_src),
		.inverting_source_select(neg_src), .inverting_input_gain(gain),
		.inverting_connected(neg_on), .power_level(power_level),
		.pwm_out(pwm_out), .row_bus_out(row_bus_out),
		.sample_strobe(sample_strobe), .sample_data(sample_data),
		.irq(irq));

	dsc_column_model u_col (
		.core_clk(core_clk), .nrst(nrst), .col_clk_en(col_clk_en),
		.sample_strobe(sample_strobe), .dec_result(dec_result));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// a hang is cut short well past the longest expected run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// counts edges until a strobe shows, bounded by limit
	task automatic wait_strobe(input int limit, output int n, output bit got);
		got = 0;
		n = 0;
		while (!got && n < limit) begin
			last_pwm = pwm_out;
			last_row = row_bus_out;
			@(posedge core_clk);
			#1;
			n++;
			got = (sample_strobe === 1'b1);
		end
	endtask

	// offset binary in, sign bit flipped and extended when signed
	function automatic logic [15:0] fmt(input logic [15:0] r, input bit s);
		logic [13:0] v;
		v = r[13:0];
		if (!s)
			return {2'b00, v};
		v[13] = ~v[13];
		return {{2{v[13]}}, v};
	endfunction

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		logic [15:0] d;
		logic [15:0] exp_s;
		int n;
		bit got;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 0;
		reg_rd = 0;
		nrst = 0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		rd(A_CTRL, d);
		`CHK("ctrl reset", 16'h001a, d)
		rd(A_DUTY, d);
		`CHK("duty reset", 16'h01ff, d)
		rd(4'hf, d);
		`CHK("unmapped read", 16'h0000, d)
		// the data clock enable pulses once every DIV core cycles
		n = 0;
		repeat (8) begin
			@(posedge core_clk);
			#1;
			n += int'(col_clk_en);
		end
		`CHK("data clock pulses", 8 / DIV, n)
		`CHK("power reset", power_level_off, power_level)
		for (int i = 0; i < 4; i++) begin
			wr(A_POWER, 16'(i));
			`CHK("power level", 2'(i), power_level)
		end
		wr(A_CMD, 16'h0001);
		`CHK("power after stop", power_level_off, power_level)
		$display("test power done");
		wr(A_INPUT, 16'h0095);
		`CHK("pos source", 4'h5, pos_src)
		`CHK("neg source", 4'h9, neg_src)
		`CHK("neg disconnected", 1'b0, neg_on)
		wr(A_INPUT, 16'h1095);
		`CHK("unity gain", 5'h10, gain)
		`CHK("neg connected", 1'b1, neg_on)
		wr(A_INPUT, 16'h1f95);
		`CHK("top gain", 5'h1f, gain)
		rd(A_INPUT, d);
		`CHK("input read", 16'h1f95, d)
		wr(A_CTRL, 16'h0006);
		`CHK("phase swap", 1'b1, ph2)
		$display("test input done");
		// rate 32 keeps a period at 256 core cycles
		wr(A_DUTY, 16'd64);
		wr(A_MASK, 16'h0001);
		wr(A_ROUTE, 16'h0005);
		rd(A_ROUTE, d);
		`CHK("route read", 16'h0005, d)
		for (int s = 1; s >= 0; s--) begin
			wr(A_CTRL, {14'h0000, 1'(s), 1'b1});
			`CHK("phase one", 1'b0, ph2)
			wait_strobe(600, n, got);
			wait_strobe(600, n, got);
			exp_s = fmt(dec_result, 1'(s));
			`CHK("sample period", PER, n)
			`CHK("pwm fall", 2'b10, {last_pwm, pwm_out})
			`CHK("row drive", 4'b0100, last_row)
			`CHK("sample data", exp_s, sample_data)
			@(posedge core_clk);
			#1;
			`CHK("irq up", 1'b1, irq)
			rd(A_SAMPLE, d);
			`CHK("sample read", exp_s, d)
			rd(A_STATUS, d);
			`CHK("status sample", 16'h0001, d)
			@(posedge core_clk);
			#1;
			`CHK("irq down", 1'b0, irq)
		end
		$display("test sampling done");
		wr(A_DUTY, 16'h0000);
		wait_strobe(600, n, got);
		`CHK("zero duty strobe", 1'b0, got)
		`CHK("zero duty pwm", 1'b0, pwm_out)
		rd(A_STATUS, d);
		`CHK("status idle", 16'h0000, d)
		wr(A_DUTY, 16'd64);
		wait_strobe(800, n, got);
		`CHK("skip two results", 1'b1, got && n > 2 * PER)
		rd(A_STATUS, d);
		`CHK("status skip", 16'h0003, d)
		wr(A_DUTY, 16'd128);
		wait_strobe(600, n, got);
		`CHK("full duty strobe", 1'b0, got)
		`CHK("full duty pwm", 1'b1, pwm_out)
		$display("test duty done");
		// a reset in mid-run must power the analog block down again
		wr(A_POWER, 16'h0002);
		`CHK("power set", 2'h2, power_level)
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		`CHK("power after reset", power_level_off, power_level)
		rd(A_CTRL, d);
		`CHK("ctrl after reset", 16'h001a, d)
		$display("test reset done");
		close_out();
	end
endmodule
